// >>> verilog/ast_pkg.sv
`default_nettype none
// ---------------------------------------------------------------
// Shared constants of the asynchronous serial transmitter.
// ---------------------------------------------------------------
package ast_pkg;
   // Register byte addresses on the AXI4-Lite slave.
   localparam logic [31:0] AST_ADDR_CTRL   = 32'h0000_0000;
   localparam logic [31:0] AST_ADDR_STATUS = 32'h0000_0004;
   localparam logic [31:0] AST_ADDR_DATA   = 32'h0000_0008;

   // Control register field positions.
   localparam int AST_CTRL_TX_EN   = 0;
   localparam int AST_CTRL_PORT_EN = 1;
   localparam int AST_CTRL_CLOCKED = 2;
   localparam int AST_CTRL_NINE_EN = 3;
   localparam int AST_CTRL_INVERT  = 4;
   localparam int AST_CTRL_IRQ_EN  = 5;
   localparam int AST_CTRL_NINTH   = 6;

   // Status register field positions.
   localparam int AST_STAT_BUF_EMPTY   = 0;
   localparam int AST_STAT_SHIFT_EMPTY = 1;
   localparam int AST_STAT_IRQ_REQ     = 2;

   // Reset values.
   localparam logic [6:0]  AST_CTRL_RESET = 7'h00;
   localparam logic [8:0]  AST_DATA_RESET = 9'h000;
   localparam logic [31:0] AST_ZERO_WORD  = 32'h0000_0000;

   // Character widths.
   localparam int          AST_CHAR_W  = 9;
   localparam logic [3:0]  AST_BITS_8  = 4'h8;
   localparam logic [3:0]  AST_BITS_9  = 4'h9;

   // AXI response codes.
   localparam logic [1:0] AST_RESP_OKAY   = 2'h0;
   localparam logic [1:0] AST_RESP_SLVERR = 2'h2;

   // Frame states, Gray coded along the usual path from idle up to stop.
   typedef enum logic [2:0] {
      AST_ST_IDLE  = 3'h0,
      AST_ST_ALIGN = 3'h1,
      AST_ST_START = 3'h3,
      AST_ST_DATA  = 3'h2,
      AST_ST_STOP  = 3'h6
   } ast_state_e;
endpackage
`default_nettype wire

// >>> verilog/ast_tx_if.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Link between the register side and the frame shifter.
// ---------------------------------------------------------------
interface ast_tx_if;
   import ast_pkg::*;
   logic                  load_valid;
   logic                  load_ready;
   logic [AST_CHAR_W-1:0] load_data;
   logic                  nine_bit;
   logic                  abort;
   logic                  busy;
   logic                  line;

   modport ctl (output load_valid, output load_data, output nine_bit,
                output abort, input load_ready, input busy, input line);
   modport shf (input load_valid, input load_data, input nine_bit,
                input abort, output load_ready, output busy, output line);
endinterface
`default_nettype wire

// >>> verilog/ast_tx_shifter.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Frame shifter: start bit, data LSb first, one stop bit.
// ---------------------------------------------------------------
module ast_tx_shifter
   import ast_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic baud_tick,
   ast_tx_if.shf     sif
);
   ast_state_e            state_ff;
   logic [AST_CHAR_W-1:0] shift_ff;
   logic [3:0]            count_ff;
   logic [3:0]            nbits_ff;
   logic                  line_ff;

   // Only an idle shifter takes a new character.
   assign sif.load_ready = (state_ff == AST_ST_IDLE) && !sif.abort;
   assign sif.busy       = (state_ff != AST_ST_IDLE);
   assign sif.line       = line_ff;

   // Sequencer; every bit changes only on a baud tick.
   always_ff @(posedge aclk) begin
      if (!aresetn || sif.abort) begin
         state_ff <= AST_ST_IDLE;
         shift_ff <= AST_DATA_RESET;
         count_ff <= 4'h0;
         nbits_ff <= AST_BITS_8;
         line_ff  <= 1'b1;
      end else begin
         case (state_ff)
            AST_ST_IDLE: begin
               line_ff <= 1'b1;
               if (sif.load_valid) begin
                  shift_ff <= sif.load_data;
                  nbits_ff <= sif.nine_bit ? AST_BITS_9 : AST_BITS_8;
                  count_ff <= 4'h0;
                  state_ff <= AST_ST_ALIGN;
               end
            end
            AST_ST_ALIGN: begin
               // Start on a tick so the start bit lasts a full period.
               if (baud_tick) begin
                  line_ff  <= 1'b0;
                  state_ff <= AST_ST_START;
               end
            end
            AST_ST_START: begin
               if (baud_tick) begin
                  line_ff  <= shift_ff[0];
                  shift_ff <= {1'b0, shift_ff[AST_CHAR_W-1:1]};
                  count_ff <= 4'h1;
                  state_ff <= AST_ST_DATA;
               end
            end
            AST_ST_DATA: begin
               if (baud_tick) begin
                  if (count_ff == nbits_ff) begin
                     line_ff  <= 1'b1;
                     state_ff <= AST_ST_STOP;
                  end else begin
                     line_ff  <= shift_ff[0];
                     shift_ff <= {1'b0, shift_ff[AST_CHAR_W-1:1]};
                     count_ff <= count_ff + 4'h1;
                  end
               end
            end
            AST_ST_STOP: begin
               if (baud_tick) begin
                  state_ff <= AST_ST_IDLE;
               end
            end
            default: begin
               state_ff <= AST_ST_IDLE;
               line_ff  <= 1'b1;
            end
         endcase
      end
   end
endmodule // ast_tx_shifter
`default_nettype wire

// >>> verilog/ast_uart_tx.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - One start, 8 or 9 data, stop bit.
// - Idle and stop are mark, start space.
// - Data bits leave least significant first.
// - Each bit lasts exactly one baud period.
// - No hardware parity; ninth bit carries it.
// - Active only when enabled, asynchronous, port on.
// - Port and transmit enable make the pin a driven output.
// - Disabled transmitter releases pin to general use.
// - Enabling sets buffer-empty flag at once.
// - Write to idle shifter starts frame immediately.
// - Queued character moves one cycle after stop.
// - Polarity resets normal; one inverts output.
// - Inversion applies only in asynchronous mode.
// - Flag set unless shifter busy and queued.
// - Flag settles second cycle after buffer write.
// - Flag is read-only to software.
// - Flag independent of enable; request needs both.
// - Shift-empty clears on load, sets when done.
// - Shift-empty status drives no interrupt.
// - Nine-bit mode sends ninth bit last.
// - Ninth bit written first, moved with byte.

// ---------------------------------------------------------------
// Asynchronous serial transmitter with an AXI4-Lite register port.
// ---------------------------------------------------------------
module ast_uart_tx
   import ast_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        baud_tick,
   input  wire logic        gpio_out,
   input  wire logic        gpio_oe,
   output logic             transmit_pin_o,
   output logic             transmit_pin_oe,
   output logic             tx_irq_req
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   ast_tx_if sif ();

   logic                  aw_held_ff;
   logic [31:0]           aw_addr_ff;
   logic                  w_held_ff;
   logic [31:0]           w_data_ff;
   logic [3:0]            w_strb_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  rvalid_ff;
   logic [31:0]           rdata_ff;
   logic [1:0]            rresp_ff;

   logic                  transmit_enable_ff;
   logic                  port_enable_ff;
   logic                  clocked_mode_ff;
   logic                  ninth_bit_enable_ff;
   logic                  tx_polarity_invert_ff;
   logic                  tx_irq_enable_ff;
   logic                  ninth_data_bit_ff;

   logic                  hold_full_ff;
   logic [AST_CHAR_W-1:0] hold_data_ff;
   logic                  empty_seen_ff;
   logic                  pin_ff;
   logic                  pin_oe_ff;

   logic                  do_write;
   logic                  wr_ctrl;
   logic                  wr_data;
   logic                  wr_mapped;
   logic                  rd_take;
   logic                  async_active;
   logic                  pin_owned;
   logic                  load_fire;
   logic                  tx_buffer_empty_flag;
   logic                  shift_empty_status;
   logic [31:0]           nxt_rdata;
   logic [1:0]            nxt_rresp;

   // ---------------------------------------------------------------
   // AXI4-Lite write channels
   // ---------------------------------------------------------------

   // Address and data are taken in either order; a new pair is
   // refused until the previous response has been accepted.
   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

   // The write is carried out once both halves are held.
   assign do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_mapped = (aw_addr_ff == AST_ADDR_CTRL)
                   || (aw_addr_ff == AST_ADDR_STATUS)
                   || (aw_addr_ff == AST_ADDR_DATA);
   assign wr_ctrl   = do_write && (aw_addr_ff == AST_ADDR_CTRL)
                   && w_strb_ff[0];
   assign wr_data   = do_write && (aw_addr_ff == AST_ADDR_DATA)
                   && w_strb_ff[0];

   // Write address capture.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= AST_ZERO_WORD;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   // Write data capture.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         w_data_ff <= AST_ZERO_WORD;
         w_strb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   // Write response; the status register simply ignores writes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= AST_RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_mapped ? AST_RESP_OKAY : AST_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channels
   // ---------------------------------------------------------------
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign rd_take       = s_axi_arvalid && s_axi_arready;

   // Read multiplexer; the holding buffer itself reads as zero.
   always_comb begin
      nxt_rdata = AST_ZERO_WORD;
      nxt_rresp = AST_RESP_OKAY;
      case (s_axi_araddr)
         AST_ADDR_CTRL: begin
            nxt_rdata[AST_CTRL_TX_EN]   = transmit_enable_ff;
            nxt_rdata[AST_CTRL_PORT_EN] = port_enable_ff;
            nxt_rdata[AST_CTRL_CLOCKED] = clocked_mode_ff;
            nxt_rdata[AST_CTRL_NINE_EN] = ninth_bit_enable_ff;
            nxt_rdata[AST_CTRL_INVERT]  = tx_polarity_invert_ff;
            nxt_rdata[AST_CTRL_IRQ_EN]  = tx_irq_enable_ff;
            nxt_rdata[AST_CTRL_NINTH]   = ninth_data_bit_ff;
         end
         AST_ADDR_STATUS: begin
            nxt_rdata[AST_STAT_BUF_EMPTY]   = tx_buffer_empty_flag;
            nxt_rdata[AST_STAT_SHIFT_EMPTY] = shift_empty_status;
            nxt_rdata[AST_STAT_IRQ_REQ]     = tx_irq_req;
         end
         AST_ADDR_DATA: begin
            nxt_rdata = AST_ZERO_WORD;
         end
         default: begin
            nxt_rresp = AST_RESP_SLVERR;
         end
      endcase
   end

   // Read data register, held until the master accepts it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= AST_ZERO_WORD;
         rresp_ff  <= AST_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------

   // All fields sit in byte lane 0; the flag bits are not stored
   // here, so no software write can touch them.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transmit_enable_ff    <= AST_CTRL_RESET[AST_CTRL_TX_EN];
         port_enable_ff        <= AST_CTRL_RESET[AST_CTRL_PORT_EN];
         clocked_mode_ff       <= AST_CTRL_RESET[AST_CTRL_CLOCKED];
         ninth_bit_enable_ff   <= AST_CTRL_RESET[AST_CTRL_NINE_EN];
         tx_polarity_invert_ff <= AST_CTRL_RESET[AST_CTRL_INVERT];
         tx_irq_enable_ff      <= AST_CTRL_RESET[AST_CTRL_IRQ_EN];
         ninth_data_bit_ff     <= AST_CTRL_RESET[AST_CTRL_NINTH];
      end else if (wr_ctrl) begin
         transmit_enable_ff    <= w_data_ff[AST_CTRL_TX_EN];
         port_enable_ff        <= w_data_ff[AST_CTRL_PORT_EN];
         clocked_mode_ff       <= w_data_ff[AST_CTRL_CLOCKED];
         ninth_bit_enable_ff   <= w_data_ff[AST_CTRL_NINE_EN];
         tx_polarity_invert_ff <= w_data_ff[AST_CTRL_INVERT];
         tx_irq_enable_ff      <= w_data_ff[AST_CTRL_IRQ_EN];
         ninth_data_bit_ff     <= w_data_ff[AST_CTRL_NINTH];
      end
   end

   // Asynchronous transmission needs all three conditions.
   assign async_active = transmit_enable_ff && !clocked_mode_ff
                      && port_enable_ff;

   // ---------------------------------------------------------------
   // Holding buffer
   // ---------------------------------------------------------------

   // Hand the queued character to the shifter as soon as it is idle,
   // which is the cycle after a write or after the stop bit ends.
   assign sif.load_valid = hold_full_ff && async_active;
   assign sif.load_data  = hold_data_ff;
   assign sif.nine_bit   = ninth_bit_enable_ff;
   assign sif.abort      = !async_active;
   assign load_fire      = sif.load_valid && sif.load_ready;

   // Occupancy; a write in the load cycle queues the new character,
   // so the write wins over the clear. Writes while inactive are lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_full_ff <= 1'b0;
      end else if (!async_active) begin
         hold_full_ff <= 1'b0;
      end else if (wr_data) begin
         hold_full_ff <= 1'b1;
      end else if (load_fire) begin
         hold_full_ff <= 1'b0;
      end
   end

   // The ninth bit is taken with the byte, so it must already be set;
   // parity, if any, is whatever software put there.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_data_ff <= AST_DATA_RESET;
      end else if (wr_data && async_active) begin
         hold_data_ff <= {ninth_data_bit_ff, w_data_ff[7:0]};
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------

   // Occupancy seen one edge late, so the flag moves in the second
   // cycle after a write. A character leaving in the same cycle
   // keeps the flag high, avoiding a false one-cycle dip.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         empty_seen_ff <= 1'b1;
      end else begin
         empty_seen_ff <= !(hold_full_ff && !load_fire);
      end
   end

   // Enabling shows the flag at once because the buffer is empty
   // then; the flag ignores the interrupt enable.
   assign tx_buffer_empty_flag = async_active && empty_seen_ff;

   // Interrupt request needs the flag and its enable.
   assign tx_irq_req = tx_buffer_empty_flag && tx_irq_enable_ff;

   // Shift-empty is polled only and feeds no request.
   assign shift_empty_status = !sif.busy;

   // ---------------------------------------------------------------
   // Transmit pin
   // ---------------------------------------------------------------

   // The unit owns the pin while port and transmitter are enabled,
   // overriding the pin direction; otherwise the general purpose
   // levels pass through.
   assign pin_owned = port_enable_ff && transmit_enable_ff;

   // Registered pin drive; inversion only outside clocked mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_ff    <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else if (pin_owned) begin
         pin_ff    <= sif.line ^ (tx_polarity_invert_ff
                                  && !clocked_mode_ff);
         pin_oe_ff <= 1'b1;
      end else begin
         pin_ff    <= gpio_out;
         pin_oe_ff <= gpio_oe;
      end
   end

   assign transmit_pin_o  = pin_ff;
   assign transmit_pin_oe = pin_oe_ff;

   // ---------------------------------------------------------------
   // Frame shifter
   // ---------------------------------------------------------------

   // Bits advance only on the one-cycle baud tick.
   ast_tx_shifter u_shifter (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .baud_tick (baud_tick),
      .sif       (sif.shf)
   );

endmodule // ast_uart_tx
`default_nettype wire

// >>> bench/ast_uart_tx_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Bus and pin checks at the transmitter top.
// ---------------
module ast_uart_tx_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic baud_tick,
   input wire logic gpio_out,
   input wire logic transmit_pin_o,
   input wire logic transmit_pin_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // The write answer comes on the second edge after both halves are taken.
   write_wait_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
   write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   read_wait_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer off time");
   read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   // The owned pin only moves two edges after a baud tick.
   pin_tick_a: assert property (
      transmit_pin_oe && $past(transmit_pin_oe) && $changed(transmit_pin_o)
      |-> $past(baud_tick, 2)) else $error("pin moved off a tick");
   gpio_pass_a: assert property (
      $past(aresetn) && !transmit_pin_oe |-> transmit_pin_o == $past(gpio_out))
      else $error("released pin not following gpio");
endmodule // ast_uart_tx_chk

bind ast_uart_tx ast_uart_tx_chk u_chk (.*);
`default_nettype wire

// >>> bench/ast_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------
// Far-end receiver that samples each bit at mid-period.
// ---------------
module ast_rx_model #(
   parameter int BAUD = 8
) (
   input  wire logic  aclk,
   input  wire logic  en,
   input  wire logic  pin,
   input  wire logic  invert,
   input  wire logic  nine,
   output logic [8:0] rx_data,
   output logic       rx_err,
   output int         rx_count
);
   logic       busy = 1'b0;
   logic [8:0] sh = 9'h000;
   int         cnt = 0;
   int         idx = 0;
   logic       lv;

   // Line level with the polarity folded out.
   assign lv = pin ^ invert;

   // Outputs start cleared.
   initial begin
      rx_data = 9'h000;
      rx_err = 1'b0;
      rx_count = 0;
   end

   // Hunt for a start level, then take start, data and stop at mid-bit.
   always @(posedge aclk) begin
      if (!en) begin
         busy <= 1'b0;
      end else if (!busy) begin
         busy <= !lv;
         cnt <= BAUD / 2;
         idx <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         cnt <= BAUD;
         idx <= idx + 1;
         if (idx == 0) begin
            busy <= !lv;
         end else if (idx <= (nine ? 9 : 8)) begin
            sh[idx-1] <= lv;
         end else begin
            busy <= 1'b0;
            rx_err <= !lv;
            rx_data <= nine ? sh : {1'b0, sh[7:0]};
            rx_count <= rx_count + 1;
         end
      end
   end
endmodule // ast_rx_model
`default_nettype wire

// >>> bench/ast_uart_tx_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ---------------
// Register-level tests of the transmitter.
// ---------------
module ast_uart_tx_tb_top;
   import ast_pkg::*;
   localparam int          BAUD = 8;
   localparam logic [1:0]  OK = AST_RESP_OKAY;
   localparam logic [31:0] CT = AST_ADDR_CTRL;
   localparam logic [31:0] ST = AST_ADDR_STATUS;
   localparam logic [31:0] DT = AST_ADDR_DATA;
   logic        aclk = 1'b0, aresetn = 1'b0, baud_tick = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        gpio_out = 1'b0, gpio_oe = 1'b0, m_inv = 1'b0, m_nine = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        transmit_pin_o, transmit_pin_oe, tx_irq_req, rx_err;
   logic [8:0]  rx_data;
   int          rx_count, cyc = 0, checked = 0, miscompares = 0;
   logic [31:0] ctl [3] = '{32'h03, 32'h4b, 32'h0b};
   logic [8:0]  dat [3] = '{9'h0a5, 9'h13c, 9'h0ff};

   ast_uart_tx DUT (.*);
   ast_rx_model #(.BAUD(BAUD)) u_rx (.aclk(aclk), .en(transmit_pin_oe), .pin(transmit_pin_o),
      .invert(m_inv), .nine(m_nine), .rx_data(rx_data), .rx_err(rx_err), .rx_count(rx_count));

   // Clock of 100 ns period.
   always #50 aclk = ~aclk;

   // Baud tick: a one-cycle pulse every BAUD clocks.
   always @(posedge aclk) begin
      cyc <= (cyc == BAUD - 1) ? 0 : cyc + 1;
      baud_tick <= (cyc == BAUD - 1);
   end

   // One bus transfer; checks answer, response code and read data together.
   task automatic bus(input logic w, input logic [31:0] a, d, input logic [1:0] er);
      logic ah, dh, rh;
      logic [31:0] q;
      logic [1:0] r;
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= {3'h7, !d[31]}; // Data bit 31 withholds byte lane 0.
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      n = 0;
      rh = 1'b0;
      while (!rh && n < 99) begin
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
         dh = s_axi_wvalid && s_axi_wready;
         rh = w ? s_axi_bvalid : s_axi_rvalid;
         r = w ? s_axi_bresp : s_axi_rresp;
         q = w ? d : s_axi_rdata;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (ah) s_axi_arvalid <= 1'b0;
         if (dh) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      `CHK({rh, r, q}, {1'b1, er, d})
   endtask

   // Waits a number of clocks, ending between edges.
   task automatic idle(input int n);
      repeat (n) @(negedge aclk);
   endtask

   // Lets the pin settle, then compares enable and level.
   task automatic pins(input logic [1:0] e);
      idle(3);
      `CHK({transmit_pin_oe, transmit_pin_o}, e)
   endtask

   // Waits for the far end to count a frame, then compares it.
   task automatic rx(input int n, input logic [8:0] e);
      int k;
      k = 0;
      while (rx_count < n && k < 400) begin
         @(negedge aclk);
         k++;
      end
      `CHK({rx_count == n, rx_err, rx_data}, {2'h2, e})
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      wrap_up;
   end

   // Main test sequence.
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      bus(0, CT, AST_ZERO_WORD, OK);
      gpio_oe <= 1'b1;
      gpio_out <= 1'b1;
      pins(2'h3);
      @(posedge aclk);
      gpio_oe <= 1'b0;
      gpio_out <= 1'b0;
      bus(1, CT, 32'h03, OK);
      pins(2'h3);
      bus(0, ST, 32'h03, OK);
      $display("test enable done");
      for (int i = 0; i < 3; i++) begin
         m_nine <= ctl[i][3];
         bus(1, CT, ctl[i], OK);
         bus(1, DT, {24'h0, dat[i][7:0]}, OK);
         rx(i + 1, dat[i]);
      end
      $display("test frames done");
      m_nine <= 1'b0;
      bus(1, CT, 32'h23, OK);
      pins(2'h3);
      `CHK(tx_irq_req, 1'b1)
      bus(1, DT, 32'h81, OK);
      bus(1, DT, 32'h7e, OK);
      bus(0, ST, 32'h00, OK);
      bus(1, CT, 32'h03, OK);
      rx(4, 9'h081);
      rx(5, 9'h07e);
      idle(BAUD);
      bus(1, ST, 32'h00, OK);
      bus(0, ST, 32'h03, OK);
      $display("test queue done");
      bus(1, CT, AST_ZERO_WORD, OK);
      m_inv <= 1'b1;
      bus(1, CT, 32'h13, OK);
      pins(2'h2);
      bus(1, DT, 32'h5a, OK);
      rx(6, 9'h05a);
      idle(BAUD);
      bus(1, CT, AST_ZERO_WORD, OK);
      m_inv <= 1'b0;
      bus(1, CT, 32'h17, OK);
      pins(2'h3);
      bus(1, DT, 32'h55, OK);
      idle(12 * BAUD);
      `CHK(rx_count, 6)
      $display("test polarity done");
      bus(1, CT, 32'h03, OK);
      bus(1, DT, 32'h00, OK);
      idle(3 * BAUD);
      bus(1, CT, 32'h01, OK);
      pins(2'h0);
      bus(1, CT, 32'h03, OK);
      bus(0, ST, 32'h03, OK);
      idle(12 * BAUD);
      `CHK(rx_count, 6)
      $display("test abort done");
      bus(1, 32'h10, 32'h01, AST_RESP_SLVERR);
      bus(0, 32'h10, AST_ZERO_WORD, AST_RESP_SLVERR);
      bus(0, DT, AST_ZERO_WORD, OK);
      bus(1, CT, 32'h8000_0000, OK);
      bus(0, CT, 32'h03, OK);
      $display("test map done");
      wrap_up;
   end
endmodule // ast_uart_tx_tb_top
`default_nettype wire
